//--- rtl/dual_comparator_control.sv
`timescale 1ns/1ps
// Overview of operation
// - Idle-stop bit set and device idle: block runs on but raises no interrupt.
// - Bits 13/12 are sticky flags set whenever comparator 2/1 output changes while it is enabled.
// - Bits 11/10 turn comparator 2/1 on when set, off when clear.
// - Bits 9/8 set: comparator result driven on its pad; clear: pad undriven.
// - Bits 5/4 invert comparator 2/1 output when set.
// - Bits 3/1 route inverting input: 1 plus pin, 0 minus pin.
// - Bits 2/0 route non-inverting input: 1 plus pin, 0 internal reference.
// - Bit 14 always reads zero and ignores writes.
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device power state, same clock domain
  input wire logic idle_mode,
  // Analog comparator decisions, plus input above minus input
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  // Analog core controls
  output logic cmp1_on,
  output logic cmp2_on,
  output logic cmp1_inverting_sel,
  output logic cmp2_inverting_sel,
  output logic cmp1_noninverting_sel,
  output logic cmp2_noninverting_sel,
  // Output pads, routed onward by the pin-select fabric
  output logic cmp1_pad_out,
  output logic cmp1_pad_oe,
  output logic cmp2_pad_out,
  output logic cmp2_pad_oe,
  // Interrupt
  output logic irq
);

  // Merge a byte-enabled write into a 16-bit word
  function automatic logic [15:0] merge16(input logic [15:0] cur,
                                          input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] res;
    res = cur;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [IRQ_WIDTH-1:0] stat_r;
  logic [IRQ_WIDTH-1:0] stat_nxt;
  logic [IRQ_WIDTH-1:0] mask_r;
  logic [IRQ_WIDTH-1:0] mask_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  // Comparator results and change pulses
  logic res1;
  logic res2;
  logic chg1;
  logic chg2;

  cmp_result_stage u_cmp1 (
    .clock(clock),
    .resetn(resetn),
    .raw(cmp1_raw),
    .enable(ctrl_r[CMP1_ON_BIT]),
    .invert(ctrl_r[CMP1_INVERT_BIT]),
    .result_r(res1),
    .change_r(chg1)
  );

  cmp_result_stage u_cmp2 (
    .clock(clock),
    .resetn(resetn),
    .raw(cmp2_raw),
    .enable(ctrl_r[CMP2_ON_BIT]),
    .invert(ctrl_r[CMP2_INVERT_BIT]),
    .result_r(res2),
    .change_r(chg2)
  );

  // Bus decode
  wire req = read | write;
  // A transfer completes on the edge where waitrequest is seen low
  wire done = req & ~wait_r;
  wire sel_ctrl = (address[3:2] == CTRL_OFS[3:2]);
  wire sel_stat = (address[3:2] == STAT_OFS[3:2]);
  wire sel_mask = (address[3:2] == MASK_OFS[3:2]);
  wire wr_ctrl = done & write & sel_ctrl;
  wire wr_mask = done & write & sel_mask;
  wire rd_stat = done & read & sel_stat;

  // Exactly one wait cycle per transfer
  assign wait_nxt = ~(req & wait_r);

  // Control word as read: live results, bit 14 forced low
  wire [15:0] ctrl_view = (ctrl_r & CTRL_WRITABLE)
                          | ({15'h0000, res2} << CMP2_RESULT_BIT)
                          | ({15'h0000, res1} << CMP1_RESULT_BIT);

  wire [31:0] rd_mux = sel_ctrl ? {16'h0000, ctrl_view} :
                       sel_stat ? {30'h00000000, stat_r} :
                       sel_mask ? {30'h00000000, mask_r} : 32'h00000000;

  // Sample read data on the edge that drops waitrequest
  assign rdata_nxt = (read & wait_r) ? rd_mux : rdata_r;

  // Software write; unwritable bits keep zero
  wire [15:0] ctrl_wr = merge16(ctrl_r, writedata[15:0], byteenable[1:0])
                        & CTRL_WRITABLE;
  wire [15:0] ctrl_base = wr_ctrl ? ctrl_wr : ctrl_r;

  // Hardware set of a change flag wins over a software clear in the same cycle
  wire [15:0] flag_set = ({15'h0000, chg2} << CMP2_FLAG_BIT)
                         | ({15'h0000, chg1} << CMP1_FLAG_BIT);
  assign ctrl_nxt = ctrl_base | flag_set;

  // Interrupt status: sticky, cleared by reading it, new events win
  wire [IRQ_WIDTH-1:0] events = {chg2, chg1};
  // Clear only what the read reported, so an event landing in the wait cycle survives
  wire [IRQ_WIDTH-1:0] stat_seen = rd_stat ? rdata_r[IRQ_WIDTH-1:0] : IRQ_RESET;
  assign stat_nxt = (stat_r & ~stat_seen) | events;

  wire [15:0] mask_wr = merge16({14'h0000, mask_r}, writedata[15:0], byteenable[1:0]);
  assign mask_nxt = wr_mask ? mask_wr[IRQ_WIDTH-1:0] : mask_r;

  // Idle suppression blocks only the request, flags keep collecting
  wire suppress = ctrl_r[IDLE_STOP_BIT] & idle_mode;
  wire flag_pending = ctrl_r[CMP2_FLAG_BIT] | ctrl_r[CMP1_FLAG_BIT];
  wire stat_pending = |(stat_r & mask_r);
  assign irq_nxt = ~suppress & flag_pending & stat_pending;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RESET;
      stat_r <= IRQ_RESET;
      mask_r <= IRQ_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Outputs
  assign readdata = rdata_r;
  assign waitrequest = wait_r;
  assign irq = irq_r;
  assign cmp1_on = ctrl_r[CMP1_ON_BIT];
  assign cmp2_on = ctrl_r[CMP2_ON_BIT];
  assign cmp1_inverting_sel = ctrl_r[CMP1_INV_SEL_BIT];
  assign cmp2_inverting_sel = ctrl_r[CMP2_INV_SEL_BIT];
  assign cmp1_noninverting_sel = ctrl_r[CMP1_NONINV_SEL_BIT];
  assign cmp2_noninverting_sel = ctrl_r[CMP2_NONINV_SEL_BIT];
  // Pad enable assumes the pin-select fabric is already mapped
  assign cmp1_pad_oe = ctrl_r[CMP1_PAD_BIT];
  assign cmp2_pad_oe = ctrl_r[CMP2_PAD_BIT];
  assign cmp1_pad_out = res1;
  assign cmp2_pad_out = res2;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_ctrl_write;
    write && !wait_r && sel_ctrl;
  endsequence

  sequence s_stat_read;
    read && !wait_r && sel_stat;
  endsequence

  sequence s_ctrl_read_start;
    read && wait_r && sel_ctrl;
  endsequence

  sequence s_stat_read_start;
    read && wait_r && sel_stat;
  endsequence

  sequence s_mask_write;
    write && !wait_r && sel_mask;
  endsequence

  a_wait_one_cycle : assert property (
      $rose(req) && wait_r |=> !wait_r ##1 wait_r)
    else $error("waitrequest did not drop for exactly one cycle");

  a_unused_bit_zero : assert property (
      read && !wait_r && sel_ctrl |-> ##1 !readdata[UNUSED_BIT])
    else $error("bit 14 read back as one");

  a_enable_follows : assert property (
      (s_ctrl_write and byteenable[1]) |=> cmp1_on == $past(writedata[CMP1_ON_BIT]))
    else $error("comparator enable not taken from write");

  a_pad_drive : assert property (
      (s_ctrl_write and byteenable[1]) |=> cmp2_pad_oe == $past(writedata[CMP2_PAD_BIT]))
    else $error("pad drive not taken from write");

  a_flag_on_change : assert property (
      chg1 |=> ctrl_r[CMP1_FLAG_BIT])
    else $error("change did not set the flag");

  a_flag_sticky : assert property (
      ctrl_r[CMP2_FLAG_BIT] && !wr_ctrl |=> ctrl_r[CMP2_FLAG_BIT])
    else $error("change flag dropped without a write");

  a_idle_quiet : assert property (
      suppress [*2] |-> !irq)
    else $error("interrupt raised while idle suppressed");

  a_irq_raise : assert property (
      !suppress && flag_pending && stat_pending |=> irq)
    else $error("pending event did not raise interrupt");

  a_invert_sense : assert property (
      ctrl_r[CMP1_ON_BIT] && $stable(ctrl_r[CMP1_INVERT_BIT]) && $rose(res1)
      |-> $past(ctrl_r[CMP1_INVERT_BIT]) ? !$past(u_cmp1.sync2_r) : $past(u_cmp1.sync2_r))
    else $error("result polarity wrong");

  a_stat_clear : assert property (
      (s_stat_read and !(|events))
      |=> (stat_r & $past(readdata[IRQ_WIDTH-1:0])) == IRQ_RESET)
    else $error("status not cleared by read");

  a_sel_follow : assert property (
      (s_ctrl_write and byteenable[0]) |=> cmp2_noninverting_sel
      == $past(writedata[CMP2_NONINV_SEL_BIT]) && cmp1_inverting_sel
      == $past(writedata[CMP1_INV_SEL_BIT]))
    else $error("input routing not taken from write");

  a_enable2_follows : assert property (
      (s_ctrl_write and byteenable[1]) |=> cmp2_on == $past(writedata[CMP2_ON_BIT]))
    else $error("comparator 2 enable not taken from write");

  a_pad1_drive : assert property (
      (s_ctrl_write and byteenable[1]) |=> cmp1_pad_oe == $past(writedata[CMP1_PAD_BIT]))
    else $error("comparator 1 pad drive not taken from write");

  a_disabled1_quiet : assert property (
      !ctrl_r[CMP1_ON_BIT] |=> !chg1)
    else $error("disabled comparator 1 reported a change");

  a_disabled2_quiet : assert property (
      !ctrl_r[CMP2_ON_BIT] |=> !chg2)
    else $error("disabled comparator 2 reported a change");

  // Read data are captured in the wait cycle, one edge before the master takes them
  a_result1_read : assert property (
      s_ctrl_read_start |=> readdata[CMP1_RESULT_BIT] == $past(res1))
    else $error("comparator 1 result not shown in control word");

  a_result2_read : assert property (
      s_ctrl_read_start |=> readdata[CMP2_RESULT_BIT] == $past(res2))
    else $error("comparator 2 result not shown in control word");

  a_invert2_sense : assert property (
      ctrl_r[CMP2_ON_BIT] && $stable(ctrl_r[CMP2_INVERT_BIT]) && $rose(res2)
      |-> $past(ctrl_r[CMP2_INVERT_BIT]) ? !$past(u_cmp2.sync2_r) : $past(u_cmp2.sync2_r))
    else $error("comparator 2 result polarity wrong");

  a_flag2_on_change : assert property (
      chg2 |=> ctrl_r[CMP2_FLAG_BIT])
    else $error("comparator 2 change did not set its flag");

  a_stat1_event : assert property (
      chg1 |=> stat_r[IRQ_CMP1_BIT])
    else $error("comparator 1 change missing from status");

  a_stat2_event : assert property (
      chg2 |=> stat_r[IRQ_CMP2_BIT])
    else $error("comparator 2 change missing from status");

  a_flag1_sticky : assert property (
      ctrl_r[CMP1_FLAG_BIT] && !wr_ctrl |=> ctrl_r[CMP1_FLAG_BIT])
    else $error("comparator 1 flag dropped without a write");

  a_flag1_clear : assert property (
      (s_ctrl_write and (byteenable[1] && !writedata[CMP1_FLAG_BIT] && !chg1))
      |=> !ctrl_r[CMP1_FLAG_BIT])
    else $error("comparator 1 flag not cleared by writing zero");

  a_flag2_clear : assert property (
      (s_ctrl_write and (byteenable[1] && !writedata[CMP2_FLAG_BIT] && !chg2))
      |=> !ctrl_r[CMP2_FLAG_BIT])
    else $error("comparator 2 flag not cleared by writing zero");

  a_idle_runs_on : assert property (
      suppress && chg1 |=> ctrl_r[CMP1_FLAG_BIT] && stat_r[IRQ_CMP1_BIT])
    else $error("idle suppression stopped event collection");

  a_idle_normal : assert property (
      !ctrl_r[IDLE_STOP_BIT] && flag_pending && stat_pending |=> irq)
    else $error("interrupt held back although idle stop is clear");

  a_irq_needs_flag : assert property (
      !flag_pending |=> !irq)
    else $error("interrupt raised with no change flag set");

  a_irq_masked : assert property (
      !stat_pending |=> !irq)
    else $error("interrupt raised with no unmasked status bit");

  a_sel2_follow : assert property (
      (s_ctrl_write and byteenable[0]) |=> cmp2_inverting_sel
      == $past(writedata[CMP2_INV_SEL_BIT]) && cmp1_noninverting_sel
      == $past(writedata[CMP1_NONINV_SEL_BIT]))
    else $error("second input routing pair not taken from write");

  a_stat_report : assert property (
      s_stat_read_start |=> readdata[IRQ_WIDTH-1:0] == $past(stat_r))
    else $error("status read returned wrong bits");

  a_mask_write : assert property (
      (s_mask_write and byteenable[0]) |=> mask_r == $past(writedata[IRQ_WIDTH-1:0]))
    else $error("mask not taken from write");

endmodule : dual_comparator_control

//--- shared/cmp_ctrl_pkg.sv
package cmp_ctrl_pkg;

  // Avalon byte offsets of the register words
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] MASK_OFS = 4'h8;

  // Control register field positions
  localparam int IDLE_STOP_BIT = 15;
  localparam int UNUSED_BIT = 14;
  localparam int CMP2_FLAG_BIT = 13;
  localparam int CMP1_FLAG_BIT = 12;
  localparam int CMP2_ON_BIT = 11;
  localparam int CMP1_ON_BIT = 10;
  localparam int CMP2_PAD_BIT = 9;
  localparam int CMP1_PAD_BIT = 8;
  localparam int CMP2_RESULT_BIT = 7;
  localparam int CMP1_RESULT_BIT = 6;
  localparam int CMP2_INVERT_BIT = 5;
  localparam int CMP1_INVERT_BIT = 4;
  localparam int CMP2_INV_SEL_BIT = 3;
  localparam int CMP2_NONINV_SEL_BIT = 2;
  localparam int CMP1_INV_SEL_BIT = 1;
  localparam int CMP1_NONINV_SEL_BIT = 0;

  // Bits that software may store; results and bit 14 are not among them
  localparam logic [15:0] CTRL_WRITABLE = 16'hBF3F;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Interrupt status and mask layout
  localparam int IRQ_CMP1_BIT = 0;
  localparam int IRQ_CMP2_BIT = 1;
  localparam int IRQ_WIDTH = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;

endpackage : cmp_ctrl_pkg

//--- rtl/cmp_result_stage.sv
`timescale 1ns/1ps
// One comparator: pin synchroniser, enable gating, polarity and change detect
module cmp_result_stage (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Analog core decision, asynchronous to clock
  input wire logic raw,
  // Configuration
  input wire logic enable,
  input wire logic invert,
  // Results
  output logic result_r,
  output logic change_r
);

  logic sync1_r;
  logic sync2_r;
  logic result_nxt;
  logic change_nxt;

  // A disabled comparator reads low and reports no changes
  assign result_nxt = enable & (sync2_r ^ invert);
  assign change_nxt = enable & (result_nxt != result_r);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_r <= 1'b0;
      change_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      change_r <= change_nxt;
    end
  end

  a_disabled_low : assert property (@(posedge clock) disable iff (!resetn)
      !enable |=> !result_r)
    else $error("disabled comparator result not low");

endmodule : cmp_result_stage

//--- tb/dual_comparator_control_bench.sv
`timescale 1ns/1ps
module dual_comparator_control_bench;
  import cmp_ctrl_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic idle_mode = 1'b0;
  logic cmp1_raw = 1'b0;
  logic cmp2_raw = 1'b0;
  logic cmp1_on, cmp2_on, cmp1_inverting_sel, cmp2_inverting_sel;
  logic cmp1_noninverting_sel, cmp2_noninverting_sel;
  logic cmp1_pad_out, cmp1_pad_oe, cmp2_pad_out, cmp2_pad_oe, irq;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] d;

  always #12.5 clock = ~clock;

  dual_comparator_control dual_comparator_control_inst (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .idle_mode(idle_mode), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .cmp1_on(cmp1_on),
    .cmp2_on(cmp2_on), .cmp1_inverting_sel(cmp1_inverting_sel),
    .cmp2_inverting_sel(cmp2_inverting_sel), .cmp1_noninverting_sel(cmp1_noninverting_sel),
    .cmp2_noninverting_sel(cmp2_noninverting_sel), .cmp1_pad_out(cmp1_pad_out),
    .cmp1_pad_oe(cmp1_pad_oe), .cmp2_pad_out(cmp2_pad_out), .cmp2_pad_oe(cmp2_pad_oe),
    .irq(irq));

  task end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task bus_write(input logic [3:0] a, input logic [15:0] v);
    address <= a;
    writedata <= {16'h0000, v};
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
    @(posedge clock);
  endtask : bus_write

  task bus_read(input logic [3:0] a, output logic [15:0] v);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    v = readdata[15:0];
    read <= 1'b0;
    @(posedge clock);
  endtask : bus_read

  task set_raw(input int i, input logic v);
    if (i == 0) cmp1_raw <= v;
    else cmp2_raw <= v;
  endtask : set_raw

  task test_reset;
    bus_read(CTRL_OFS, d);
    check({16'h0, d}, 32'h0, "control reset");
    bus_read(MASK_OFS, d);
    check({16'h0, d}, 32'h0, "mask reset");
    check({27'h0, irq, cmp1_on, cmp2_on, cmp1_pad_oe, cmp2_pad_oe}, 32'h0, "outputs reset");
  endtask : test_reset

  task test_config;
    bus_write(CTRL_OFS, 16'h403F);
    bus_read(CTRL_OFS, d);
    check({16'h0, d}, 32'h003F, "bit 14 stays zero");
    check({28'h0, cmp2_inverting_sel, cmp2_noninverting_sel, cmp1_inverting_sel,
      cmp1_noninverting_sel}, 32'hF, "selects set");
    bus_write(CTRL_OFS, 16'h0005);
    check({28'h0, cmp2_inverting_sel, cmp2_noninverting_sel, cmp1_inverting_sel,
      cmp1_noninverting_sel}, 32'h5, "selects split");
    bus_write(4'hC, 16'hFFFF);
    bus_read(4'hC, d);
    check({16'h0, d}, 32'h0, "unmapped reads zero");
    bus_read(CTRL_OFS, d);
    check({16'h0, d}, 32'h0005, "unmapped write ignored");
    byteenable <= 4'h1;
    bus_write(CTRL_OFS, 16'hFF30);
    byteenable <= 4'hF;
    bus_read(CTRL_OFS, d);
    check({16'h0, d}, 32'h0030, "upper lane untouched");
  endtask : test_config

  task test_compare;
    logic [15:0] base, res_b, flg_b, inv_b;
    for (int i = 0; i < 2; i++) begin
      base = (16'h0400 << i) | (16'h0100 << i);
      res_b = 16'h0040 << i;
      flg_b = 16'h1000 << i;
      inv_b = 16'h0010 << i;
      bus_write(CTRL_OFS, 16'h0000);
      set_raw(i, 1'b1);
      repeat (6) @(posedge clock);
      bus_read(CTRL_OFS, d);
      check({16'h0, d}, 32'h0, "off comparator silent");
      bus_write(CTRL_OFS, base);
      repeat (6) @(posedge clock);
      bus_read(CTRL_OFS, d);
      check({16'h0, d}, {16'h0, base | res_b | flg_b}, "result and flag");
      check({30'h0, cmp2_pad_oe, cmp1_pad_oe}, 32'h1 << i, "pad driven");
      check({30'h0, cmp2_on, cmp1_on}, 32'h1 << i, "comparator on");
      check({30'h0, cmp2_pad_out, cmp1_pad_out}, 32'h1 << i, "pad value");
      bus_write(CTRL_OFS, base | inv_b);
      repeat (6) @(posedge clock);
      bus_read(CTRL_OFS, d);
      check({16'h0, d}, {16'h0, base | inv_b | flg_b}, "inverted result");
      check({30'h0, cmp2_pad_out, cmp1_pad_out}, 32'h0, "inverted pad");
      bus_write(CTRL_OFS, base | inv_b);
      repeat (6) @(posedge clock);
      bus_read(CTRL_OFS, d);
      check({16'h0, d}, {16'h0, base | inv_b}, "flag cleared by zero");
      bus_write(CTRL_OFS, 16'h0000);
      set_raw(i, 1'b0);
      repeat (6) @(posedge clock);
      bus_write(CTRL_OFS, 16'h0000);
    end
  endtask : test_compare

  task test_irq;
    bus_read(STAT_OFS, d);
    bus_write(CTRL_OFS, 16'h0400);
    cmp1_raw <= 1'b1;
    repeat (6) @(posedge clock);
    check({31'h0, irq}, 32'h0, "masked event quiet");
    bus_write(MASK_OFS, 16'h0001);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h1, "unmasked event raises");
    idle_mode <= 1'b1;
    bus_write(CTRL_OFS, 16'h9400);
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0, "idle suppresses");
    idle_mode <= 1'b0;
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h1, "active again");
    bus_read(STAT_OFS, d);
    check({16'h0, d}, 32'h1, "status sticky");
    repeat (3) @(posedge clock);
    check({31'h0, irq}, 32'h0, "read clears status");
    bus_read(STAT_OFS, d);
    check({16'h0, d}, 32'h0, "status empty");
  endtask : test_irq

  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    test_reset();
    test_config();
    test_compare();
    test_irq();
    end_of_test();
  end
endmodule : dual_comparator_control_bench
